// ---- rtl/cidx_pkg.sv ----
// Purpose: shared constants and types of the CAN indexed register access block
// Assumes: 8-bit special function register bus, 16-bit indexed CAN register space
// Notes: offsets, field positions and reset values are each named once here
package cidx_pkg;
  // ************************************************
  // special function register map (page 1)
  // ************************************************
  localparam logic [7:0] SFR_PAGE_CAN = 8'h01;
  localparam logic [7:0] SFR_CTRL = 8'hF8;
  localparam logic [7:0] SFR_STAT = 8'hC0;
  localparam logic [7:0] SFR_TEST = 8'hDB;
  localparam logic [7:0] SFR_DATL = 8'hD8;
  localparam logic [7:0] SFR_DATH = 8'hD9;
  localparam logic [7:0] SFR_ADR = 8'hDA;
  // ************************************************
  // indexed register space
  // ************************************************
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_STAT = 8'h01;
  localparam logic [7:0] IDX_BT = 8'h03;
  localparam logic [7:0] IDX_TEST = 8'h05;
  localparam logic [7:0] IDX_PRESCALER_EXTENSION_VALUE = 8'h06;
  localparam logic [7:0] IDX_IF1 = 8'h08;
  localparam logic [7:0] IDX_IF2 = 8'h20;
  localparam logic [7:0] IDX_IF_SPAN = 8'h0A;
  localparam logic [7:0] IDX_TXR1 = 8'h40;
  localparam logic [7:0] IDX_NEW1 = 8'h48;
  localparam logic [7:0] IDX_INTP1 = 8'h50;
  localparam logic [7:0] IDX_VAL1 = 8'h58;
  localparam logic [7:0] IDX_SPACE = 8'h80;
  // ************************************************
  // reset values and field positions
  // ************************************************
  localparam logic [15:0] CTRL_RST = 16'h0001;
  localparam logic [15:0] BT_RST = 16'h2301;
  localparam logic [15:0] CMDREQ_RST = 16'h0001;
  localparam logic [15:0] MASK_RST = 16'hFFFF;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam int BT_SEG2_LSB = 12;
  localparam int BT_SEG1_LSB = 8;
  localparam int BT_SJW_LSB = 6;
  localparam int BT_BRP_LSB = 0;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_CCE_BIT = 6;
  localparam int CTRL_TEST_BIT = 7;
  localparam int TEST_RX_BIT = 7;
  localparam int CMASK_WR_BIT = 7;
  localparam int RAM_ARB2 = 3;
  localparam int RAM_MCTL = 4;
  localparam int ARB2_VAL_BIT = 15;
  localparam int MCTL_NEWDAT_BIT = 15;
  localparam int MCTL_INTPND_BIT = 13;
  localparam int MCTL_TXRQST_BIT = 8;
  localparam int IF_WORDS = 11;
  localparam int RAM_FIRST = 2;
  localparam int RAM_WORDS = 9;
  localparam int NUM_OBJ = 32;
  localparam int XFER_W = 7;
  localparam int FIFO_DEPTH = 8;
  // transfer engine, gray along idle-copy-done
  typedef enum logic [1:0] {
    CIDX_IDLE = 2'b00,
    CIDX_COPY = 2'b01,
    CIDX_DONE = 2'b11
  } cidx_xfer_t;
endpackage : cidx_pkg

// ---- rtl/cidx_fifo_if.sv ----
// Purpose: valid/ready carrier between the access block and its request queue
// Assumes: single clock domain
// Notes: user side pushes and pops, queue side answers
`timescale 1ns/1ps
`default_nettype none
interface cidx_fifo_if #(parameter int W = 7) ();
  logic [W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [W-1:0] rdata;
  logic rvalid;
  logic rready;
  modport fifo (input wdata, input wvalid, input rready,
                output wready, output rdata, output rvalid);
  modport user (output wdata, output wvalid, output rready,
                input wready, input rdata, input rvalid);
endinterface : cidx_fifo_if
`default_nettype wire

// ---- rtl/cidx_fifo.sv ----
// Purpose: flop-based queue of message transfer requests
// Assumes: W and DEPTH set the structure; DEPTH is a power of two
// Notes: full and empty are exact; push while full is refused by wready low
`timescale 1ns/1ps
`default_nettype none
module cidx_fifo #(
  parameter int W = 7,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  cidx_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // handshakes
  assign q.wready = (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
  assign q.rvalid = (cnt_reg != '0);
  assign q.rdata = mem_reg[rptr_reg];
  assign push = q.wvalid & q.wready;
  assign pop = q.rready & q.rvalid;

  // storage
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
    end else if (push) begin
      mem_reg[wptr_reg] <= q.wdata;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + AW'(1);
      if (pop) rptr_reg <= rptr_reg + AW'(1);
      if (push && !pop) cnt_reg <= cnt_reg + (AW+1)'(1);
      else if (pop && !push) cnt_reg <= cnt_reg - (AW+1)'(1);
    end
  end

  // queue never overflows nor underflows
  fifo_bound_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("queue count past depth");
endmodule : cidx_fifo
`default_nettype wire

// ---- rtl/cidx_top.sv ----
// Purpose: CAN indexed register window, direct byte registers, message transfers
// Assumes: 8-bit register bus qualified by page select; one 40 MHz clock
// Notes: protocol engine lies outside; error and interrupt words read zero
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] timing word: seg2, seg1, jump width, prescaler
// [R2] software writes after-sample length minus one
// [R3] software writes before-sample length minus one
// [R4] software writes prescaler minus one
// [R5] software sets init and change enable first
// [R6] software loads index 3, writes high, low
// [R7] two interface sets reach message RAM
// [R8] command request number starts object transfer
// [R9] message handler words are read only
// [R10] index selects among 128 sixteen-bit words
// [R11] low byte via low, high via high
// [R12] low data register is bit addressable
// [R13] software writes index, high, then low
// [R14] control, status, test direct on page 1
// [R15] other registers only through the index
// [R16] interface ranges advance index on low access
// [R17] timing writes need change enable set; the extension prescaler write needs the test bit instead
// [R18] extension prescaler is value plus one
// [R19] low write commits whole sixteen-bit word
// [R20] reads return selected word's two bytes
module cidx_top
  import cidx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic sfr_bit_val_i,
  input wire logic can_rx_i,
  output logic [7:0] sfr_rdata_o,
  output logic init_o,
  output logic [15:0] bit_timing_o,
  output logic [4:0] prescaler_ext_o,
  output logic xfer_busy_o,
  output logic push_ready_o,
  output logic [NUM_OBJ-1:0] object_valid_flags_o
);
  // ************************************************
  // registers
  // ************************************************
  logic [7:0] index_reg, data_high_reg, status_reg;
  logic [15:0] ctrl_reg, bit_timing_reg;
  logic [6:0] test_reg;
  logic [3:0] prescaler_extension_value_reg;
  logic [15:0] if_reg [2][IF_WORDS];
  logic [15:0] ram_reg [NUM_OBJ][RAM_WORDS];
  logic [2:0] rx_sync_reg;
  logic rx_reg;
  cidx_xfer_t state_reg;
  logic [3:0] word_reg;
  logic [XFER_W-1:0] job_reg;
  logic [NUM_OBJ-1:0] txr_flags, new_flags, intp_flags;
  logic [15:0] sel_word, commit_word;
  logic [7:0] low_byte, if_ofs;
  logic on_page, lo_wr, lo_acc, in_if1, in_if2, direct_wr;
  cidx_fifo_if #(.W(XFER_W)) q ();
  cidx_fifo #(.W(XFER_W), .DEPTH(FIFO_DEPTH)) u_queue (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .q(q)
  );
  // ************************************************
  // bus decode
  // ************************************************
  assign on_page = (sfr_page_i == SFR_PAGE_CAN);
  assign direct_wr = sfr_wr_i & on_page;
  assign lo_wr = on_page & (sfr_addr_i == SFR_DATL) & (sfr_wr_i | sfr_bit_wr_i);
  assign lo_acc = lo_wr | (on_page & sfr_rd_i & (sfr_addr_i == SFR_DATL));
  assign in_if1 = (index_reg >= IDX_IF1) && (index_reg <= IDX_IF1 + IDX_IF_SPAN);
  assign in_if2 = (index_reg >= IDX_IF2) && (index_reg <= IDX_IF2 + IDX_IF_SPAN);
  assign if_ofs = index_reg - (in_if2 ? IDX_IF2 : IDX_IF1);
  // bit write merges one bit into the current low byte
  always_comb begin
    low_byte = sfr_wdata_i;
    if (sfr_bit_wr_i) begin
      low_byte = sel_word[7:0];
      low_byte[sfr_bit_sel_i] = sfr_bit_val_i; // [R12]
    end
  end
  assign commit_word = {data_high_reg, low_byte}; // [R19]
  // handler flags pulled from each object's stored words
  for (genvar o = 0; o < NUM_OBJ; o++) begin : g_flags
    assign object_valid_flags_o[o] = ram_reg[o][RAM_ARB2][ARB2_VAL_BIT];
    assign txr_flags[o] = ram_reg[o][RAM_MCTL][MCTL_TXRQST_BIT];
    assign new_flags[o] = ram_reg[o][RAM_MCTL][MCTL_NEWDAT_BIT];
    assign intp_flags[o] = ram_reg[o][RAM_MCTL][MCTL_INTPND_BIT];
  end
  // word selected by the index; unmapped words read zero
  always_comb begin
    sel_word = ZERO_RST;
    if (in_if1) sel_word = if_reg[0][if_ofs[3:0]];
    else if (in_if2) sel_word = if_reg[1][if_ofs[3:0]];
    else begin
      case (index_reg) // [R10]
        IDX_CTRL: sel_word = ctrl_reg;
        IDX_STAT: sel_word = {8'h00, status_reg};
        IDX_BT: sel_word = bit_timing_reg;
        IDX_TEST: sel_word = {8'h00, rx_reg, test_reg};
        IDX_PRESCALER_EXTENSION_VALUE: sel_word = {12'h000, prescaler_extension_value_reg};
        IDX_TXR1: sel_word = txr_flags[15:0]; // [R9]
        IDX_TXR1 + 8'h01: sel_word = txr_flags[31:16];
        IDX_NEW1: sel_word = new_flags[15:0];
        IDX_NEW1 + 8'h01: sel_word = new_flags[31:16];
        IDX_INTP1: sel_word = intp_flags[15:0];
        IDX_INTP1 + 8'h01: sel_word = intp_flags[31:16];
        IDX_VAL1: sel_word = object_valid_flags_o[15:0];
        IDX_VAL1 + 8'h01: sel_word = object_valid_flags_o[31:16];
        default: sel_word = ZERO_RST;
      endcase
    end
  end
  // read data, registered one cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i && on_page) begin
      case (sfr_addr_i)
        SFR_DATL: sfr_rdata_o <= sel_word[7:0]; // [R11] [R20]
        SFR_DATH: sfr_rdata_o <= sel_word[15:8]; // [R20]
        SFR_ADR: sfr_rdata_o <= index_reg;
        SFR_CTRL: sfr_rdata_o <= ctrl_reg[7:0]; // [R14]
        SFR_STAT: sfr_rdata_o <= status_reg;
        SFR_TEST: sfr_rdata_o <= {rx_reg, test_reg};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end
  // ************************************************
  // index pointer and high byte holding
  // ************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      index_reg <= 8'h00;
    end else if (direct_wr && sfr_addr_i == SFR_ADR) begin
      index_reg <= sfr_wdata_i & (IDX_SPACE - 8'h01);
    end else if (lo_acc && (in_if1 || in_if2)) begin
      index_reg <= index_reg + 8'h01; // [R16]
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) data_high_reg <= 8'h00;
    else if (direct_wr && sfr_addr_i == SFR_DATH) data_high_reg <= sfr_wdata_i; // [R11]
  end
  // ************************************************
  // protocol registers, direct or indexed
  // ************************************************
  // only control, status and test have direct addresses
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= CTRL_RST;
      status_reg <= 8'h00;
      test_reg <= 7'h00;
    end else begin
      if (direct_wr && sfr_addr_i == SFR_CTRL) ctrl_reg[7:0] <= sfr_wdata_i; // [R14]
      else if (lo_wr && index_reg == IDX_CTRL) ctrl_reg <= commit_word;
      if (direct_wr && sfr_addr_i == SFR_STAT) status_reg <= sfr_wdata_i; // [R14]
      else if (lo_wr && index_reg == IDX_STAT) status_reg <= commit_word[7:0];
      if (direct_wr && sfr_addr_i == SFR_TEST) test_reg <= sfr_wdata_i[6:0]; // [R14]
      else if (lo_wr && index_reg == IDX_TEST) test_reg <= commit_word[6:0];
    end
  end
  // timing words reachable through the index only
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_timing_reg <= BT_RST;
      prescaler_extension_value_reg <= 4'h0;
    end else begin
      if (lo_wr && index_reg == IDX_BT && ctrl_reg[CTRL_CCE_BIT]) // [R15] [R17]
        bit_timing_reg <= commit_word; // [R1]
      if (lo_wr && index_reg == IDX_PRESCALER_EXTENSION_VALUE && ctrl_reg[CTRL_TEST_BIT])
        prescaler_extension_value_reg <= commit_word[3:0];
    end
  end
  assign init_o = ctrl_reg[CTRL_INIT_BIT];
  assign bit_timing_o = bit_timing_reg;
  assign prescaler_ext_o = {1'b0, prescaler_extension_value_reg} + 5'h01; // [R18]
  // receive pin, three stages; level taken once the last two agree
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_sync_reg <= 3'b111;
      rx_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], can_rx_i};
      if (rx_sync_reg[1] == rx_sync_reg[2]) rx_reg <= rx_sync_reg[2];
    end
  end
  // ************************************************
  // interface sets and message transfers
  // ************************************************
  // a request naming object 1..32 is queued; queue full refuses it
  assign q.wvalid = lo_wr && (in_if1 || in_if2) && if_ofs == 8'h00 &&
                    commit_word[5:0] != 6'h00 && commit_word[5:0] <= 6'(NUM_OBJ); // [R8]
  assign q.wdata = {in_if2, if_reg[in_if2][1][CMASK_WR_BIT], 5'(commit_word[5:0] - 6'h01)};
  assign q.rready = (state_reg == CIDX_IDLE);
  assign push_ready_o = q.wready;
  assign xfer_busy_o = (state_reg != CIDX_IDLE);
  // engine copies nine words one per cycle, which lets the queue back up
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= CIDX_IDLE;
      word_reg <= 4'h0;
      job_reg <= '0;
    end else begin
      case (state_reg)
        CIDX_IDLE: if (q.rvalid) begin
          job_reg <= q.rdata;
          word_reg <= 4'h0;
          state_reg <= CIDX_COPY;
        end
        CIDX_COPY: begin
          word_reg <= word_reg + 4'h1;
          if (word_reg == 4'(RAM_WORDS - 1)) state_reg <= CIDX_DONE;
        end
        CIDX_DONE: state_reg <= CIDX_IDLE;
        default: state_reg <= CIDX_IDLE;
      endcase
    end
  end
  // interface words: the engine outranks a host write in the same cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int s = 0; s < 2; s++) begin // [R7]
        for (int w = 0; w < IF_WORDS; w++) if_reg[s][w] <= ZERO_RST;
        if_reg[s][0] <= CMDREQ_RST;
        if_reg[s][2] <= MASK_RST;
        if_reg[s][3] <= MASK_RST;
      end
    end else begin
      if (lo_wr && (in_if1 || in_if2)) if_reg[in_if2][if_ofs[3:0]] <= commit_word;
      if (state_reg == CIDX_COPY && !job_reg[5]) // [R8]
        if_reg[job_reg[6]][RAM_FIRST + int'(word_reg)] <= ram_reg[job_reg[4:0]][word_reg];
    end
  end
  // message memory written only by the engine
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int o = 0; o < NUM_OBJ; o++)
        for (int w = 0; w < RAM_WORDS; w++) ram_reg[o][w] <= ZERO_RST;
    end else if (state_reg == CIDX_COPY && job_reg[5]) begin
      ram_reg[job_reg[4:0]][word_reg] <= if_reg[job_reg[6]][RAM_FIRST + int'(word_reg)]; // [R8]
    end
  end
  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_bt_write;
    lo_wr && index_reg == IDX_BT && ctrl_reg[CTRL_CCE_BIT];
  endsequence
  sequence s_job_taken;
    state_reg == CIDX_IDLE && q.rvalid;
  endsequence
  bt_commit_a: assert property (s_bt_write |=> bit_timing_reg == $past(commit_word)) // [R19]
    else $error("timing word not committed");
  bt_locked_a: assert property (lo_wr && !ctrl_reg[CTRL_CCE_BIT] |=> $stable(bit_timing_reg)) // [R17]
    else $error("timing word changed while locked");
  bt_fields_a: assert property (s_bt_write ##1 1 |-> bit_timing_o[15:12] == $past(data_high_reg[7:4])) // [R1]
    else $error("after-sample field misplaced");
  index_step_a: assert property (lo_acc && (in_if1 || in_if2) && !(direct_wr && sfr_addr_i == SFR_ADR)
    |=> index_reg == $past(index_reg) + 8'h01) // [R16]
    else $error("index did not advance");
  index_hold_a: assert property (lo_acc && !in_if1 && !in_if2 && !direct_wr |=> $stable(index_reg)) // [R16]
    else $error("index moved outside interface range");
  read_low_a: assert property (sfr_rd_i && on_page && sfr_addr_i == SFR_DATL
    |=> sfr_rdata_o == $past(sel_word[7:0])) // [R20]
    else $error("low read wrong byte");
  flags_ro_a: assert property (lo_wr && index_reg == IDX_VAL1 && state_reg == CIDX_IDLE
    |=> $stable(object_valid_flags_o)) // [R9]
    else $error("handler flags written by host");
  xfer_len_a: assert property (s_job_taken |=> xfer_busy_o [*8] ##1 xfer_busy_o ##1 xfer_busy_o
    ##1 !xfer_busy_o) // [R8]
    else $error("transfer length wrong");
  direct_ctrl_a: assert property (direct_wr && sfr_addr_i == SFR_CTRL
    |=> ctrl_reg[7:0] == $past(sfr_wdata_i)) // [R14]
    else $error("direct control write lost");
  presc_a: assert property (lo_wr && index_reg == IDX_PRESCALER_EXTENSION_VALUE && ctrl_reg[CTRL_TEST_BIT]
    |=> prescaler_ext_o == {1'b0, $past(commit_word[3:0])} + 5'h01) // [R18]
    else $error("prescaler not extension plus one");
endmodule : cidx_top
`default_nettype wire

// ---- tb/cidx_can_node.sv ----
// Purpose: behavioural CAN node on the far side of the receive pin
// Assumes: bus idles recessive (high) through the transceiver
// Notes: dominant_i from the bench pulls the line low
`timescale 1ns/1ps
`default_nettype none
module cidx_can_node (
  input wire logic ref_clk_i,
  input wire logic dominant_i,
  output logic can_rx_o
);
  // ************************************************
  // receive line
  // ************************************************
  // registered so the level moves away from the bench's own edge
  initial can_rx_o = 1'b1;
  // plain always: the initial value above is a second writer
  always @(posedge ref_clk_i) begin
    can_rx_o <= ~dominant_i;
  end
endmodule : cidx_can_node
`default_nettype wire

// ---- tb/can_indexed_access_and_bit_timing_tb.sv ----
// Purpose: self-checking bench of the indexed CAN register window
// Assumes: 40 MHz clock, async active-low reset, page 0x01 selects the block
// Notes: inputs change on the falling edge; random timing words from an lfsr
`timescale 1ns/1ps
`default_nettype none
module can_indexed_access_and_bit_timing_tb
  import cidx_pkg::*;
;
  // ************************************************
  // stimulus and observed signals
  // ************************************************
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] sfr_page_i = SFR_PAGE_CAN;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_bit_wr_i = 1'b0;
  logic [2:0] sfr_bit_sel_i = 3'h0;
  logic sfr_bit_val_i = 1'b0;
  logic dominant = 1'b0;
  logic can_rx;
  logic [7:0] rdata;
  logic init;
  logic [15:0] bt;
  logic [4:0] pext;
  logic busy;
  logic pready;
  logic [NUM_OBJ-1:0] flags;
  int fails = 0;
  int compares = 0;
  // 25 ns period
  always #12.5 ref_clk_i = ~ref_clk_i;
  cidx_top u_cidx_top (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .sfr_page_i(sfr_page_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_sel_i(sfr_bit_sel_i),
    .sfr_bit_val_i(sfr_bit_val_i), .can_rx_i(can_rx), .sfr_rdata_o(rdata), .init_o(init),
    .bit_timing_o(bt), .prescaler_ext_o(pext), .xfer_busy_o(busy), .push_ready_o(pready),
    .object_valid_flags_o(flags));
  cidx_can_node u_cidx_can_node (.ref_clk_i(ref_clk_i), .dominant_i(dominant),
    .can_rx_o(can_rx));
  // ************************************************
  // expectation helpers
  // ************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr
  // segment lengths in quanta, each field holds length minus one
  function automatic logic [15:0] bt_word(input int seg2, input int seg1, input int resync_jump_width,
                                          input int quantum_prescaler);
    return 16'(((seg2 - 1) << 12) | ((seg1 - 1) << 8) | ((resync_jump_width - 1) << 6) | (quantum_prescaler - 1));
  endfunction : bt_word
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk16
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk32
  // ************************************************
  // register bus cycles
  // ************************************************
  // strobe held across one rising edge, released at the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_rd_i = 1'b0;
    d = rdata;
  endtask : rd
  // index first, then high, then low: the low write commits
  task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
    wr(SFR_ADR, idx);
    wr(SFR_DATH, v[15:8]);
    wr(SFR_DATL, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
    wr(SFR_ADR, idx);
    rd(SFR_DATH, v[15:8]);
    rd(SFR_DATL, v[7:0]);
  endtask : rd16
  // idle for three cycles in a row means the queue has drained
  task automatic wait_idle();
    int n;
    n = 0;
    for (int i = 0; i < 2000 && n < 3; i++) begin
      @(negedge ref_clk_i);
      n = (busy === 1'b0) ? n + 1 : 0;
    end
    if (n < 3) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, busy, 1'b0);
    end
  endtask : wait_idle
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // ************************************************
  // watchdog and main sequence
  // ************************************************
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    finish_test();
  end
  initial begin
    logic [15:0] v;
    logic [7:0] b;
    logic [31:0] r;
    logic full_seen;
    r = 32'h5ecb;
    full_seen = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    chk16(bt, BT_RST);
    chk8({3'h0, pext}, 8'h01);
    chk32(flags, 32'h0);
    rd(SFR_CTRL, b);
    chk8(b, CTRL_RST[7:0]);
    // another page leaves the block deaf: read data holds, writes dropped
    sfr_page_i = 8'h0F;
    rd(SFR_STAT, b);
    chk8(b, CTRL_RST[7:0]);
    wr(SFR_CTRL, 8'h00);
    sfr_page_i = SFR_PAGE_CAN;
    rd(8'h03, b);
    chk8(b, 8'h00);
    rd(8'h55, b);
    chk8(b, 8'h00);
    chk8({7'h0, init}, 8'h01);
    // timing write refused while change enable is clear
    wr16(IDX_BT, 16'h5EC0);
    chk16(bt, BT_RST);
    wr(SFR_CTRL, 8'h41);
    rd16(IDX_CTRL, v);
    chk8(v[7:0], 8'h41);
    wr16(IDX_BT, bt_word(6, 15, 4, 1));
    chk16(bt, 16'h5EC0);
    rd16(IDX_BT, v);
    chk16(v, 16'h5EC0);
    rd(SFR_ADR, b);
    chk8(b, IDX_BT);
    // single bit write into the low data register
    @(negedge ref_clk_i);
    sfr_addr_i = SFR_DATL;
    sfr_bit_sel_i = 3'h0;
    sfr_bit_val_i = 1'b1;
    sfr_bit_wr_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_bit_wr_i = 1'b0;
    chk16(bt, 16'h5EC1);
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      v = bt_word(int'(r[2:0]) + 2, int'(r[7:4]) + 1, int'(r[9:8]) + 1, int'(r[15:10]) + 1);
      wr16(IDX_BT, v);
      chk16(bt, v);
    end
    // auto increment inside the interface ranges, including the top word
    wr16(IDX_IF1 + 8'h02, 16'h1234);
    wr(SFR_DATL, 8'h56);
    rd(SFR_ADR, b);
    chk8(b, IDX_IF1 + 8'h04);
    wr16(IDX_IF1 + 8'h0A, 16'h0000);
    rd(SFR_ADR, b);
    chk8(b, 8'h13);
    // interface one writes object 5, interface two reads it back
    wr16(IDX_IF1 + 8'h01, 16'h0080);
    wr16(IDX_IF1 + 8'h05, 16'h8000);
    wr16(IDX_IF1, 16'h0005);
    // queued at the write edge, engine picks it up one edge later
    chk8({7'h0, busy}, 8'h00);
    @(negedge ref_clk_i);
    chk8({7'h0, busy}, 8'h01);
    wait_idle();
    chk32(flags, 32'h00000010);
    wr16(IDX_IF2 + 8'h01, 16'h0000);
    wr16(IDX_IF2, 16'h0005);
    wait_idle();
    rd16(IDX_IF2 + 8'h05, v);
    chk16(v, 16'h8000);
    rd(SFR_ADR, b);
    chk8(b, IDX_IF2 + 8'h06);
    wr16(IDX_IF2 + 8'h01, 16'h0080);
    wr16(IDX_IF2, 16'h0020);
    wait_idle();
    chk32(flags, 32'h80000010);
    wr16(IDX_VAL1, 16'h0000);
    rd16(IDX_VAL1, v);
    chk16(v, 16'h0010);
    rd16(IDX_VAL1 + 8'h01, v);
    chk16(v, 16'h8000);
    // requests arrive faster than jobs finish, so the queue must fill
    for (int i = 0; i < 20; i++) begin
      wr(SFR_ADR, IDX_IF1);
      wr(SFR_DATL, 8'h01);
      if (pready === 1'b0) full_seen = 1'b1;
    end
    chk8({7'h0, full_seen}, 8'h01);
    wait_idle();
    chk8({7'h0, pready}, 8'h01);
    chk32(flags, 32'h80000011);
    // extension prescaler gated by the test bit
    wr16(IDX_PRESCALER_EXTENSION_VALUE, 16'h0003);
    chk8({3'h0, pext}, 8'h01);
    wr(SFR_CTRL, 8'hC1);
    wr16(IDX_PRESCALER_EXTENSION_VALUE, 16'h000F);
    chk8({3'h0, pext}, 8'h10);
    // receive pin seen in the test byte
    dominant = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    wr(SFR_TEST, 8'h05);
    rd(SFR_TEST, b);
    chk8(b, 8'h05);
    dominant = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    rd(SFR_TEST, b);
    chk8(b, 8'h85);
    wr(SFR_CTRL, 8'h40);
    chk8({7'h0, init}, 8'h00);
    // status byte written directly, read back through the index
    wr(SFR_STAT, 8'hA5);
    rd16(IDX_STAT, v);
    chk16(v, 16'h00A5);
    finish_test();
  end
endmodule : can_indexed_access_and_bit_timing_tb
`default_nettype wire
